/* File: damping_filter_param_ctrl.v */
// Function
// - fourth frequency 0..3000 in 0.1 Hz; values 0..4 disable the channel
// - filter setting 0..1500, clamped to min(frequency, 3000 minus frequency)
// - depth 0..1000; zero deepest, depth falls as value rises
// - width 10..1000 used directly; 0..9 behaves as 100
// - model filter active only in position control with two-dof enabled
// - conventional unless 5.0 <= anti <= resonance <= 300.0 Hz
// - conventional unless anti <= response <= 4*anti <= 300.0 Hz
// - selection 4, both models on, ratio product above 8: second conventional
// - conventional maps anti to frequency, anti ratio to depth, response
// - model function off only when all five model values are zero
// - new values apply after compute delay; a switch holds them off
//
// Our own choices: the APB register port and the placing of the registers.
`include "damping_filter_defs.vh"
`default_nettype none

module damping_filter_param_ctrl #(
    parameter COMPUTE_CYCLES = `DF_COMPUTE_CYCLES
) (
    input  wire        clk_sys,
    input  wire        rst_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        posCtrlMode,
    input  wire        twoDofEnable,
    input  wire        filterSwitch,
    output reg  [15:0] dampFreq,
    output reg  [15:0] dampSetting,
    output reg  [15:0] dampDepth,
    output reg  [15:0] dampWidth,
    output reg         dampEnable,
    output reg  [1:0]  modelActive,
    output reg  [1:0]  modelConventional,
    output reg  [1:0]  modelOff,
    output reg  [31:0] convFreq,
    output reg  [31:0] convDepth,
    output reg  [31:0] convSetting,
    output reg         updatePending
);

    // reload value of the computation delay counter
    localparam [15:0] COMPUTE_LOAD = COMPUTE_CYCLES[15:0];

    // software registers
    reg  [15:0] freq_r;
    reg  [15:0] setting_r;
    reg  [15:0] depth_r;
    reg  [15:0] width_r;
    reg  [3:0]  swSel_r;
    reg  [31:0] modelReg_r [0:5];

    // pin synchronisers and edge history
    reg  [2:0]  posSync_r;
    reg  [2:0]  dofSync_r;
    reg  [2:0]  swSync_r;
    reg  [15:0] delayCnt_r;

    // bus decode; accessPh is the access phase, done its last edge
    reg         hit;
    reg  [31:0] readMux;
    reg  [31:0] statusWord;
    wire        accessPh = psel & penable;
    wire        done     = accessPh & pready;
    wire        wrEn     = done & pwrite & hit;
    wire [7:0]  modelOfs = paddr - `DF_OFF_MODEL_BASE;
    wire [2:0]  modelIdx = modelOfs[4:2];
    wire        modelHit = (paddr >= `DF_OFF_MODEL_BASE) &&
                           (paddr <= `DF_OFF_MODEL_LAST) &&
                           (paddr[1:0] == 2'b00);

    // synchronised pin levels and events
    wire        posCtrl   = posSync_r[1];
    wire        twoDof    = dofSync_r[1];
    wire        modeEdge  = (posSync_r[1] ^ posSync_r[2]) |
                            (dofSync_r[1] ^ dofSync_r[2]);
    wire        switchEvt = swSync_r[1] ^ swSync_r[2];

    // fourth channel next values
    reg  [15:0] setLimit;
    reg  [15:0] settingNxt;
    reg  [15:0] widthNxt;
    wire        enableNxt = (freq_r > `DF_FREQ_OFF_MAX);

    // per-model evaluation
    wire [1:0]  off;
    wire [1:0]  ok;
    wire [15:0] antiF [0:1];
    wire [15:0] antiA [0:1];
    wire [15:0] respF [0:1];

    // address decode and read data; an unmapped offset clears hit
    // so the slave can answer it with an error
    always @*
    begin
        hit = 1'b1;
        readMux = `DF_RST_WORD;
        case (paddr)
            `DF_OFF_FREQ:    readMux = {16'h0000, freq_r};
            `DF_OFF_SETTING: readMux = {16'h0000, setting_r};
            `DF_OFF_DEPTH:   readMux = {16'h0000, depth_r};
            `DF_OFF_WIDTH:   readMux = {16'h0000, width_r};
            `DF_OFF_CTRL:    readMux = {28'h0000000, swSel_r};
            `DF_OFF_STATUS:  readMux = statusWord;
            default:
            begin
                if (modelHit)
                    readMux = modelReg_r[modelIdx];
                else
                    hit = 1'b0;
            end
        endcase
    end

    // status word assembled field by field from the applied set and the pending flag
    always @*
    begin
        statusWord = `DF_RST_WORD;
        statusWord[`DF_ST_ENABLE]           = dampEnable;
        statusWord[`DF_ST_ACTIVE_LO +: 2]   = modelActive;
        statusWord[`DF_ST_CONV_LO +: 2]     = modelConventional;
        statusWord[`DF_ST_OFF_LO +: 2]      = modelOff;
        statusWord[`DF_ST_PENDING]          = updatePending;
        statusWord[`DF_ST_SETTING_LO +: 16] = dampSetting;
    end

    // apb slave: one wait state, error on unmapped address
    // pready toggles, so every access phase lasts exactly two cycles;
    // prdata is launched with pready and holds its value until the next access
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= `DF_RST_WORD;
        end
        else
        begin
            pready  <= accessPh & ~pready;
            pslverr <= accessPh & ~pready & ~hit;
            if (accessPh && !pready)
                prdata <= pwrite ? `DF_RST_WORD : readMux;
        end
    end

    // register writes with range clamping at entry
    // clamping here lets readback show the range-limited value, before the setting limit and width default;
    // the status offset is read-only; a write stores nothing and raises no error but still starts the computation delay
    always @(posedge clk_sys or negedge rst_n)
    begin : regWrite
        integer i;
        if (!rst_n)
        begin
            freq_r    <= `DF_RST_PARAM;
            setting_r <= `DF_RST_PARAM;
            depth_r   <= `DF_RST_PARAM;
            width_r   <= `DF_RST_PARAM;
            swSel_r   <= 4'h0;
            for (i = 0; i < 6; i = i + 1)
                modelReg_r[i] <= `DF_RST_WORD;
        end
        else if (wrEn)
        begin
            case (paddr)
                `DF_OFF_FREQ:
                    freq_r <= (pwdata[15:0] > `DF_FREQ_MAX) ?
                              `DF_FREQ_MAX : pwdata[15:0];
                `DF_OFF_SETTING:
                    setting_r <= (pwdata[15:0] > `DF_SETTING_MAX) ?
                                 `DF_SETTING_MAX : pwdata[15:0];
                `DF_OFF_DEPTH:
                    depth_r <= (pwdata[15:0] > `DF_DEPTH_MAX) ?
                               `DF_DEPTH_MAX : pwdata[15:0];
                `DF_OFF_WIDTH:
                    width_r <= (pwdata[15:0] > `DF_WIDTH_MAX) ?
                               `DF_WIDTH_MAX : pwdata[15:0];
                `DF_OFF_CTRL:
                    swSel_r <= pwdata[`DF_CTRL_SWSEL_HI:0];
                default:
                begin
                    if (modelHit)
                        modelReg_r[modelIdx] <= pwdata;
                end
            endcase
        end
    end

    // two-flop synchronisers plus one history flop for edges
    // the third flop only remembers the last synchronised level,
    // so a toggle of either polarity gives one single-cycle event
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            posSync_r <= 3'b000;
            dofSync_r <= 3'b000;
            swSync_r  <= 3'b000;
        end
        else
        begin
            posSync_r <= {posSync_r[1:0], posCtrlMode};
            dofSync_r <= {dofSync_r[1:0], twoDofEnable};
            swSync_r  <= {swSync_r[1:0], filterSwitch};
        end
    end

    // fourth channel setting clamp and width default
    // the setting never exceeds the distance to either band edge
    always @*
    begin
        if (freq_r < (`DF_FREQ_MAX - freq_r))
            setLimit = freq_r;
        else
            setLimit = `DF_FREQ_MAX - freq_r;
        settingNxt = (setting_r > setLimit) ? setLimit : setting_r;
        widthNxt = (width_r < `DF_WIDTH_MIN) ?
                   `DF_WIDTH_DEFAULT : width_r;
    end

    // per-model range checks and disable detection
    // a model counts as off only when all five values are zero;
    // any nonzero value keeps it at least in conventional mode
    genvar m;
    generate
        for (m = 0; m < 2; m = m + 1)
        begin : model
            wire [15:0] resF  = modelReg_r[3*m][31:16];
            wire [15:0] resA  = modelReg_r[3*m+1][31:16];
            wire [17:0] anti4 = {antiF[m], 2'b00};
            assign antiF[m] = modelReg_r[3*m][15:0];
            assign antiA[m] = modelReg_r[3*m+1][15:0];
            assign respF[m] = modelReg_r[3*m+2][15:0];
            assign off[m] = (resF == 16'h0000) && (resA == 16'h0000) &&
                            (antiF[m] == 16'h0000) &&
                            (antiA[m] == 16'h0000) &&
                            (respF[m] == 16'h0000);
            assign ok[m] = (antiF[m] >= `DF_MODEL_MIN) &&
                           (antiF[m] <= resF) &&
                           ({2'b00, resF} <= `DF_MODEL_MAX) &&
                           (respF[m] >= antiF[m]) &&
                           ({2'b00, respF[m]} <= anti4) &&
                           (anti4 <= `DF_MODEL_MAX);
        end
    endgenerate

    // mode selection across both model filters
    // a model that is not off but may not run model-type falls back
    // to conventional, so exactly one of the three states holds
    wire        runModel  = posCtrl & twoDof;
    wire [1:0]  capable   = ok & ~off;
    wire [31:0] respProd  = {16'h0000, respF[0]} *
                            {16'h0000, respF[1]};
    wire [31:0] antiProd  = {16'h0000, antiF[0]} *
                            {16'h0000, antiF[1]};
    wire [34:0] respWide  = {3'b000, respProd};
    wire [34:0] antiWide  = {3'b000, antiProd} << `DF_RATIO_LIMIT;
    wire        ratioTrip = (swSel_r == `DF_SWSEL_PAIR) && runModel &&
                            (capable == 2'b11) &&
                            (respWide > antiWide);
    wire [1:0]  activeNxt = {capable[1] & runModel & ~ratioTrip,
                             capable[0] & runModel};
    wire [1:0]  convNxt   = ~off & ~activeNxt;

    // computation delay, restarted by changes and by filter switches
    // a switch while pending holds the new set off for a full delay;
    // apply is blocked in the cycle that a restart arrives
    wire        change = wrEn | modeEdge;
    wire        apply  = updatePending && (delayCnt_r == 16'h0001) &&
                         !switchEvt && !change;

    // pending flag and delay counter; a change wins over apply
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            delayCnt_r    <= 16'h0000;
            updatePending <= 1'b0;
        end
        else if (change || (updatePending && switchEvt))
        begin
            delayCnt_r    <= COMPUTE_LOAD;
            updatePending <= 1'b1;
        end
        else if (apply)
        begin
            delayCnt_r    <= 16'h0000;
            updatePending <= 1'b0;
        end
        else if (updatePending)
            delayCnt_r <= delayCnt_r - 16'h0001;
    end

    // applied coefficient set, all fields updated on one edge
    // fields only move together, so the filter never sees a mix
    // of old and new coefficients or an old mode with new values
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dampFreq          <= `DF_RST_PARAM;
            dampSetting       <= `DF_RST_PARAM;
            dampDepth         <= `DF_RST_PARAM;
            dampWidth         <= `DF_WIDTH_DEFAULT;
            dampEnable        <= 1'b0;
            modelActive       <= 2'b00;
            modelConventional <= 2'b00;
            modelOff          <= 2'b11;
            convFreq          <= `DF_RST_WORD;
            convDepth         <= `DF_RST_WORD;
            convSetting       <= `DF_RST_WORD;
        end
        else if (apply)
        begin
            dampFreq          <= freq_r;
            dampEnable        <= enableNxt;
            dampSetting       <= settingNxt;
            dampDepth         <= depth_r;
            dampWidth         <= widthNxt;
            modelActive       <= activeNxt;
            modelConventional <= convNxt;
            modelOff          <= off;
            convFreq    <= {convNxt[1] ? antiF[1] : 16'h0000,
                            convNxt[0] ? antiF[0] : 16'h0000};
            convDepth   <= {convNxt[1] ? antiA[1] : 16'h0000,
                            convNxt[0] ? antiA[0] : 16'h0000};
            convSetting <= {convNxt[1] ? respF[1] : 16'h0000,
                            convNxt[0] ? respF[0] : 16'h0000};
        end
    end

endmodule // damping_filter_param_ctrl

`default_nettype wire

/* File: damping_filter_defs.vh */
`ifndef DAMPING_FILTER_DEFS_VH
`define DAMPING_FILTER_DEFS_VH

// register byte offsets on the apb bus
`define DF_OFF_FREQ        8'h00
`define DF_OFF_SETTING     8'h04
`define DF_OFF_DEPTH       8'h08
`define DF_OFF_WIDTH       8'h0c
`define DF_OFF_CTRL        8'h10
`define DF_OFF_STATUS      8'h14
`define DF_OFF_MODEL_BASE  8'h18
`define DF_OFF_MODEL_LAST  8'h2c

// reset values of the software registers
`define DF_RST_PARAM       16'h0000
`define DF_RST_WORD        32'h00000000

// fourth channel limits, frequencies in 0.1 Hz
`define DF_FREQ_MAX        16'h0bb8
`define DF_FREQ_OFF_MAX    16'h0004
`define DF_SETTING_MAX     16'h05dc
`define DF_DEPTH_MAX       16'h03e8
`define DF_WIDTH_MAX       16'h03e8
`define DF_WIDTH_MIN       16'h000a
`define DF_WIDTH_DEFAULT   16'h0064

// model-type limits, frequencies in 0.1 Hz
`define DF_MODEL_MIN       16'h0032
`define DF_MODEL_MAX       18'h00bb8
`define DF_RATIO_LIMIT     3
`define DF_SWSEL_PAIR      4'h4

// control and status field positions
`define DF_CTRL_SWSEL_HI   3
`define DF_ST_ENABLE       0
`define DF_ST_ACTIVE_LO    1
`define DF_ST_CONV_LO      3
`define DF_ST_OFF_LO       5
`define DF_ST_PENDING      7
`define DF_ST_SETTING_LO   16

// coefficient computation delay
`define DF_COMPUTE_TIME_NS 1000
`define DF_CLK_PERIOD_NS   20
`define DF_COMPUTE_CYCLES \
    ((`DF_COMPUTE_TIME_NS + `DF_CLK_PERIOD_NS - 1) / `DF_CLK_PERIOD_NS)

`endif

/* File: dfpc_checker.sv */
`default_nettype none
module dfpc_checker (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [15:0] dampFreq,
    input wire logic [15:0] dampSetting,
    input wire logic [15:0] dampWidth,
    input wire logic        dampEnable,
    input wire logic [1:0]  modelActive,
    input wire logic [1:0]  modelConventional,
    input wire logic        updatePending
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_freq_max: assert property (dampFreq <= 16'h0bb8)
        else $error("applied frequency above range");
    a_enable_level: assert property (dampEnable == (dampFreq > 16'h0004))
        else $error("enable does not follow frequency");
    a_setting_clamp: assert property (dampSetting <= dampFreq
        && dampSetting <= 16'h0bb8 - dampFreq)
        else $error("setting unclamped");
    a_width_floor: assert property (dampWidth >= 16'h000a)
        else $error("width below usable range");
    a_wait_state: assert property (psel && !penable ##1 psel && penable
        |-> !pready ##1 pready) else $error("pready not after one wait");
    a_err_unmapped: assert property (pready && paddr > 8'h2c |-> pslverr)
        else $error("unmapped access without error");
    a_write_pends: assert property (pready && pwrite && !pslverr
        && paddr != 8'h14 |=> updatePending) else $error("write not pending");
    a_apply_edge: assert property (!$stable({dampFreq, dampSetting,
        modelActive, modelConventional}) |-> $past(updatePending)
        && !updatePending) else $error("outputs moved outside apply");
    a_hold_delay: assert property ($rose(updatePending)
        |-> updatePending[*4]) else $error("apply came too early");
    a_mode_excl: assert property (
        (modelActive & modelConventional) == 2'b00)
        else $error("model both active and conventional");
    // main scenarios reached
    c_apply: cover property ($fell(updatePending));
    c_error: cover property (pready && pslverr);
    c_pair: cover property (modelActive == 2'b01 &&
        modelConventional == 2'b10);
endmodule // dfpc_checker
bind damping_filter_param_ctrl dfpc_checker dfpc_checker_i (.clk_sys(clk_sys),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .dampFreq(dampFreq),
    .dampSetting(dampSetting), .dampWidth(dampWidth), .dampEnable(dampEnable),
    .modelActive(modelActive), .modelConventional(modelConventional),
    .updatePending(updatePending));
`default_nettype wire

/* File: cmd_gen_model.sv */
`default_nettype none
module cmd_gen_model (
    input  wire logic       clk_sys,
    input  wire logic [1:0] modeReq,
    input  wire logic       toggleReq,
    output wire logic       posCtrlMode,
    output wire logic       twoDofEnable,
    output wire logic       filterSwitch
);
    timeunit 1ns;
    timeprecision 1ps;
    // loop pin levels start idle and move just after an edge
    logic [2:0] pinLevel = 3'b000;
    always @(posedge clk_sys)
    begin
        pinLevel <= {modeReq, pinLevel[0] ^ toggleReq};
    end
    assign {posCtrlMode, twoDofEnable, filterSwitch} = pinLevel;
endmodule // cmd_gen_model
`default_nettype wire

/* File: testbench.sv */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
    logic        tgl, er, pm, td, fs, de, up;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, cf, cd, cs;
    logic [15:0] fq, st, dp, wd;
    logic [1:0]  md, ma, mc, mo;
    int          fail_count = 0;
    int          compares = 0;
    cmd_gen_model cmd_gen_model_i (.clk_sys(clk_sys), .modeReq(md),
        .toggleReq(tgl), .posCtrlMode(pm), .twoDofEnable(td),
        .filterSwitch(fs));
    damping_filter_param_ctrl #(
        .COMPUTE_CYCLES(8)
    ) damping_filter_param_ctrl_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .posCtrlMode(pm),
        .twoDofEnable(td), .filterSwitch(fs), .dampFreq(fq),
        .dampSetting(st), .dampDepth(dp), .dampWidth(wd), .dampEnable(de),
        .modelActive(ma), .modelConventional(mc), .modelOff(mo),
        .convFreq(cf), .convDepth(cd), .convSetting(cs),
        .updatePending(up));
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
            @(posedge clk_sys);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    // wait for a pending update to start and then be applied
    task automatic settle();
        while (up !== 1'b1)
            @(posedge clk_sys);
        while (up !== 1'b0)
            @(posedge clk_sys);
    endtask
    task automatic wrs(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        settle();
    endtask
    task automatic t_basic();
        chk(wd, 16'h0064);
        chk(mo, 2'b11);
        wrs(8'h00, 32'h4);
        chk(de, 1'b0);
        wrs(8'h00, 32'h5);
        chk(de, 1'b1);
        wrs(8'h00, 32'h1000);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'hbb8);
        wrs(8'h04, 32'h5dc);
        chk(st, 16'h0);
        wrs(8'h00, 32'haf0);
        chk(st, 16'hc8);
        wrs(8'h00, 32'h1f4);
        chk(st, 16'h1f4);
        wrs(8'h08, 32'h4b0);
        chk(dp, 16'h3e8);
        wrs(8'h0c, 32'h9);
        chk(wd, 16'h64);
        wrs(8'h0c, 32'ha);
        chk(wd, 16'ha);
        apb(1'b0, 8'h30, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        $display("test basic done");
    endtask
    task automatic t_switch();
        apb(1'b1, 8'h00, 32'h64);
        tgl <= 1'b1;
        @(posedge clk_sys);
        tgl <= 1'b0;
        repeat (8) @(posedge clk_sys);
        chk(fq, 16'h1f4);
        settle();
        chk(fq, 16'h64);
        $display("test switch done");
    endtask
    task automatic t_model();
        md <= 2'b11;
        wrs(8'h18, {16'd1000, 16'd100});
        wrs(8'h1c, {16'd0, 16'd30});
        wrs(8'h20, 32'd200);
        chk({ma, mc, mo}, 6'b01_00_10);
        md <= 2'b00;
        settle();
        chk({ma, mc}, 4'b0001);
        chk(cf, {16'd0, 16'd100});
        chk(cd, {16'd0, 16'd30});
        chk(cs, {16'd0, 16'd200});
        md <= 2'b11;
        wrs(8'h18, {16'd1000, 16'd40});
        wrs(8'h20, 32'd100);
        chk({ma, mc}, 4'b0001);
        wrs(8'h18, {16'd1000, 16'd100});
        wrs(8'h20, 32'd500);
        chk({ma, mc}, 4'b0001);
        wrs(8'h20, 32'd400);
        chk({ma, mc}, 4'b0100);
        md <= 2'b10;
        settle();
        chk({ma, mc}, 4'b0001);
        md <= 2'b11;
        wrs(8'h10, 32'h4);
        wrs(8'h24, {16'd2000, 16'd100});
        wrs(8'h2c, 32'd300);
        chk({ma, mc, mo}, 6'b01_10_00);
        wrs(8'h24, 32'h0);
        wrs(8'h2c, 32'h0);
        chk(mo, 2'b10);
        apb(1'b0, 8'h14, 32'h0);
        chk(rd, 32'h00640043);
        $display("test model done");
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        stop_test();
    end
    initial
    begin
        {rst_n, psel, penable, pwrite, tgl, md} = 7'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_basic();
        t_switch();
        t_model();
        stop_test();
    end
endmodule // testbench
`default_nettype wire
